// *** pkg/sac_pkg.sv ***
package sac_pkg;
  // register addresses on the byte-wide port
  localparam logic [3:0] ADDR_TIMER_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_TIMER_STAT   = 4'h1;
  localparam logic [3:0] ADDR_CNT_HIGH     = 4'h2;
  localparam logic [3:0] ADDR_CNT_LOW      = 4'h3;
  localparam logic [3:0] ADDR_CMP_HIGH     = 4'h4;
  localparam logic [3:0] ADDR_CMP_LOW      = 4'h5;
  localparam logic [3:0] ADDR_CAP_HIGH     = 4'h6;
  localparam logic [3:0] ADDR_CAP_LOW      = 4'h7;
  localparam logic [3:0] ADDR_ANALOG_CTRL  = 4'h8;
  localparam logic [3:0] ADDR_ANALOG_STAT  = 4'h9;
  // timer control fields
  localparam int TCR_CAPTURE_IRQ_EN_BIT = 7;
  localparam int TCR_MATCH_IRQ_EN_BIT   = 6;
  localparam int TCR_WRAP_IRQ_EN_BIT    = 5;
  localparam int TCR_EDGE_SEL_BIT       = 1;
  // timer status fields
  localparam int TSR_CAPTURE_BIT = 7;
  localparam int TSR_MATCH_BIT   = 6;
  localparam int TSR_WRAP_BIT    = 5;
  // analog control fields
  localparam int ACR_MODE_LOW_BIT   = 0;
  localparam int ACR_MODE_HIGH_BIT  = 1;
  localparam int ACR_SRC_SEL_BIT    = 2;
  localparam int ACR_CHARGE_BIT     = 3;
  // analog status fields
  localparam int ASR_COMPARATOR2_LIVE_OUTPUT_FLAG_BIT  = 7;
  localparam int ASR_COMPARATOR2_LIVE_OUTPUT_LIVE_BIT  = 6;
  localparam int ASR_COMPARATOR2_LIVE_OUTPUT_RESET_BIT = 1;
  // reset and wrap values
  localparam logic [15:0] CNT_RESET_VAL  = 16'hfffc;
  localparam logic [15:0] CNT_WRAP_VAL   = 16'hffff;
  localparam logic [7:0]  TCR_RESET_VAL  = 8'h00;
  localparam logic [7:0]  ACR_RESET_VAL  = 8'h00;
  // conversion modes {mode_high, mode_low}
  localparam logic [1:0] MODE_WRAP_START  = 2'h2;
  localparam logic [1:0] MODE_MATCH_START = 2'h3;
endpackage

// *** hw/sac_capture_edge.sv ***
`timescale 1ns/1ps
// picks the capture source and detects the selected edge
module sac_capture_edge
  import sac_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic resetn_i,
  input  wire logic pin_i,
  input  wire logic comp_i,
  input  wire logic src_sel_i,
  input  wire logic rise_sel_i,
  output wire logic event_o
);
  logic src;
  logic prev_reg;
  logic valid_reg;

  // source mux; the edge select inverts the sense of detection
  assign src     = src_sel_i ? comp_i : pin_i;
  assign event_o = valid_reg && (rise_sel_i ? (src && !prev_reg) : (!src && prev_reg));

  // valid gate hides the first cycle so a high source is not a false edge after reset
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      prev_reg  <= 1'b0;
      valid_reg <= 1'b0;
    end
    else
    begin
      prev_reg  <= src;
      valid_reg <= 1'b1;
    end
  end
endmodule

// *** hw/sac_ctrl.sv ***
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module sac_ctrl
  import sac_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       capture_input_pin_i,
  input  wire logic       comparator2_i,
  output logic            ramp_charge_o,
  output logic            ramp_discharge_o
);
  logic [15:0] counter_reg;
  logic [15:0] compare_reg;
  logic [15:0] capture_reg;
  logic [7:0]  timer_control_reg;
  logic [7:0]  analog_control_reg;
  logic        wrap_flag_reg;
  logic        match_flag_reg;
  logic        capture_flag_reg;
  logic        comparator2_live_output_flag_reg;
  logic        wrap_arm_reg;
  logic        match_arm_reg;
  logic        capture_arm_reg;
  logic        charge_reg;
  logic        discharge_reg;
  logic [7:0]  rdata_reg;

  // bus decode
  wire rd_stat    = rd_i && (addr_i == ADDR_TIMER_STAT);
  wire rd_cnt_lo  = rd_i && (addr_i == ADDR_CNT_LOW);
  wire rd_cmp_lo  = rd_i && (addr_i == ADDR_CMP_LOW);
  wire rd_cap_lo  = rd_i && (addr_i == ADDR_CAP_LOW);
  wire wr_tcr     = wr_i && (addr_i == ADDR_TIMER_CTRL);
  wire wr_cmp_hi  = wr_i && (addr_i == ADDR_CMP_HIGH);
  wire wr_cmp_lo  = wr_i && (addr_i == ADDR_CMP_LOW);
  wire wr_acr     = wr_i && (addr_i == ADDR_ANALOG_CTRL);
  wire wr_asr     = wr_i && (addr_i == ADDR_ANALOG_STAT);

  // timer events
  wire counter_wrap = (counter_reg == CNT_WRAP_VAL);
  wire cap_event;
  wire wrap_clr     = rd_cnt_lo && wrap_arm_reg;
  wire match_clr    = rd_cmp_lo && match_arm_reg;
  wire capture_clr  = rd_cap_lo && capture_arm_reg;
  // a clear in the same cycle reopens the lockout so the new event wins
  wire match_take   = (counter_reg == compare_reg) && (!match_flag_reg || match_clr);
  wire capture_take = cap_event && (!capture_flag_reg || capture_clr);
  wire comparator2_live_output_clr     = wr_asr && wdata_i[ASR_COMPARATOR2_LIVE_OUTPUT_RESET_BIT];

  // ramp steering
  wire [1:0] mode     = {analog_control_reg[ACR_MODE_HIGH_BIT],
                         analog_control_reg[ACR_MODE_LOW_BIT]};
  wire auto_mode      = (mode == MODE_WRAP_START) || (mode == MODE_MATCH_START);
  wire start_flag     = (mode == MODE_WRAP_START) ? wrap_flag_reg : match_flag_reg;
  wire ramp_end       = auto_mode && capture_flag_reg;
  wire ramp_start     = auto_mode && !capture_flag_reg && start_flag;

  wire charge_next    = ramp_end ? 1'b0 :
                        ramp_start ? 1'b1 :
                        wr_acr ? wdata_i[ACR_CHARGE_BIT] : charge_reg;

  wire [7:0] tsr_value = {capture_flag_reg, match_flag_reg, wrap_flag_reg, 5'h00};
  wire [7:0] asr_value = {comparator2_live_output_flag_reg, comparator2_i, 6'h00};
  wire [7:0] acr_value = {analog_control_reg[7:4], charge_reg, analog_control_reg[2:0]};

  // read mux; unmapped addresses read zero
  wire [7:0] rdata_next =
    !rd_i                        ? 8'h00 :
    (addr_i == ADDR_TIMER_CTRL)  ? timer_control_reg :
    (addr_i == ADDR_TIMER_STAT)  ? tsr_value :
    (addr_i == ADDR_CNT_HIGH)    ? counter_reg[15:8] :
    (addr_i == ADDR_CNT_LOW)     ? counter_reg[7:0] :
    (addr_i == ADDR_CMP_HIGH)    ? compare_reg[15:8] :
    (addr_i == ADDR_CMP_LOW)     ? compare_reg[7:0] :
    (addr_i == ADDR_CAP_HIGH)    ? capture_reg[15:8] :
    (addr_i == ADDR_CAP_LOW)     ? capture_reg[7:0] :
    (addr_i == ADDR_ANALOG_CTRL) ? acr_value :
    (addr_i == ADDR_ANALOG_STAT) ? asr_value : 8'h00;

  sac_capture_edge u_edge
  (
    .clk_i      (clk_i),
    .resetn_i   (resetn_i),
    .pin_i      (capture_input_pin_i),
    .comp_i     (comparator2_i),
    .src_sel_i  (analog_control_reg[ACR_SRC_SEL_BIT]),
    .rise_sel_i (timer_control_reg[TCR_EDGE_SEL_BIT]),
    .event_o    (cap_event)
  );

  // free-running counter, reloaded near wrap by reset
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      counter_reg <= CNT_RESET_VAL;
    else
      counter_reg <= counter_reg + 16'h0001;
  end

  // compare value has no reset on purpose, so a match may come any time
  always_ff @(posedge clk_i)
  begin
    if (wr_cmp_hi)
      compare_reg[15:8] <= wdata_i;
    if (wr_cmp_lo)
      compare_reg[7:0] <= wdata_i;
  end

  // capture latch holds while the flag blocks new events
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      capture_reg <= 16'h0000;
    else if (capture_take)
      capture_reg <= counter_reg;
  end

  // control registers
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      timer_control_reg  <= TCR_RESET_VAL;
      analog_control_reg <= ACR_RESET_VAL;
    end
    else
    begin
      if (wr_tcr)
        timer_control_reg <= wdata_i;
      if (wr_acr)
        analog_control_reg <= wdata_i;
    end
  end

  // flags: a set in the clearing cycle wins
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      wrap_flag_reg    <= 1'b0;
      match_flag_reg   <= 1'b0;
      capture_flag_reg <= 1'b0;
      comparator2_live_output_flag_reg    <= 1'b0;
    end
    else
    begin
      wrap_flag_reg    <= counter_wrap || (wrap_flag_reg && !wrap_clr);
      match_flag_reg   <= match_take || (match_flag_reg && !match_clr);
      capture_flag_reg <= capture_take || (capture_flag_reg && !capture_clr);
      comparator2_live_output_flag_reg    <= comparator2_i || (comparator2_live_output_flag_reg && !comparator2_live_output_clr);
    end
  end

  // arming: a status read with the flag set enables the low byte read to clear it
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      wrap_arm_reg    <= 1'b0;
      match_arm_reg   <= 1'b0;
      capture_arm_reg <= 1'b0;
    end
    else
    begin
      wrap_arm_reg    <= rd_stat ? wrap_flag_reg : (wrap_arm_reg && !rd_cnt_lo);
      match_arm_reg   <= rd_stat ? match_flag_reg : (match_arm_reg && !rd_cmp_lo);
      capture_arm_reg <= rd_stat ? capture_flag_reg : (capture_arm_reg && !rd_cap_lo);
    end
  end

  // ramp drive; discharge is the complement so the pin never floats mid-cycle
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      charge_reg    <= 1'b0;
      discharge_reg <= 1'b1;
      rdata_reg     <= 8'h00;
    end
    else
    begin
      charge_reg    <= charge_next;
      discharge_reg <= !charge_next;
      rdata_reg     <= rdata_next;
    end
  end

  assign rdata_o          = rdata_reg;
  assign ramp_charge_o    = charge_reg;
  assign ramp_discharge_o = discharge_reg;

  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  chk_wrap_sets: assert property (counter_reg == CNT_WRAP_VAL |=> wrap_flag_reg)
    else $error("wrap flag not set after counter wrap");
  chk_wrap_clear_order: assert property
    ($fell(wrap_flag_reg) |-> $past(rd_cnt_lo) && $past(wrap_arm_reg))
    else $error("wrap flag cleared without status then low byte read");
  chk_reset_value: assert property
    ($rose(resetn_i) |-> counter_reg == CNT_RESET_VAL)
    else $error("counter not at reload value after reset");
  chk_match_sets: assert property
    (counter_reg == compare_reg && !match_flag_reg |=> match_flag_reg)
    else $error("match flag not set on compare equality");
  chk_match_clear: assert property
    ($fell(match_flag_reg) |-> $past(rd_cmp_lo) && $past(match_arm_reg))
    else $error("match flag cleared out of sequence");
  chk_capture_hold: assert property
    (capture_flag_reg && !capture_clr |=> $stable(capture_reg))
    else $error("capture value changed while locked");
  chk_capture_latch: assert property
    (cap_event && !capture_flag_reg |=> capture_flag_reg && capture_reg == $past(counter_reg))
    else $error("capture did not latch counter");
  chk_capture_clear: assert property
    ($fell(capture_flag_reg) |-> $past(rd_cap_lo) && $past(capture_arm_reg))
    else $error("capture flag cleared out of sequence");
  chk_ramp_end: assert property
    (auto_mode && capture_flag_reg |=> !ramp_charge_o && ramp_discharge_o)
    else $error("ramp still charging after capture");
  chk_ramp_start: assert property
    (mode == MODE_WRAP_START && wrap_flag_reg && !capture_flag_reg |=> ramp_charge_o)
    else $error("pending wrap flag did not start ramp");
  chk_comparator2_live_output_reset: assert property
    (comparator2_live_output_clr && !comparator2_i |=> !comparator2_live_output_flag_reg)
    else $error("comparator 2 flag not cleared by reset bit");
  chk_charge_write: assert property
    (wr_acr && !auto_mode && wdata_i[ACR_CHARGE_BIT] |=> ramp_charge_o)
    else $error("charge bit write did not start current source");

  cov_wrap_conversion: cover property
    (mode == MODE_WRAP_START && $rose(ramp_charge_o) ##[1:300] $fell(ramp_charge_o));
  cov_match_conversion: cover property
    (mode == MODE_MATCH_START && $rose(ramp_charge_o) ##[1:300] capture_flag_reg);
  cov_capture_relock: cover property (capture_clr && cap_event);
endmodule

// *** sim/sac_ramp_model.sv ***
`timescale 1ns/1ps
// ramp capacitor and comparator 2; the bench may pin the comparator level
module sac_ramp_model (
  input  wire logic       clk_i,
  input  wire logic       charge_i,
  input  wire logic       discharge_i,
  input  wire logic       force_en_i,
  input  wire logic       force_val_i,
  input  wire logic [7:0] thresh_i,
  output logic            cmp_o
);
  int level = 0;
  // integer ramp; leakage and absorption are not modelled
  always @(posedge clk_i)
  begin
    if (discharge_i)
      level <= 0;
    else if (charge_i)
      level <= level + 1;
    cmp_o <= force_en_i ? force_val_i : (level >= int'(thresh_i));
  end
endmodule

// *** sim/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import sac_pkg::*;
  logic        clk_i     = 1'b0;
  logic        resetn_i  = 1'b0;
  logic [3:0]  addr_i    = 4'h0;
  logic [7:0]  wdata_i   = 8'h00;
  logic        wr_i      = 1'b0;
  logic        rd_i      = 1'b0;
  logic        pin_i     = 1'b1;
  logic        force_en  = 1'b1;
  logic        force_val = 1'b0;
  logic [7:0]  thresh    = 8'h20;
  logic [7:0]  rdata_o;
  logic        comparator2_live_output;
  logic        charge;
  logic        discharge;
  logic [15:0] cnt_m;
  logic [15:0] t;
  logic [15:0] v;
  logic [15:0] c;
  logic [7:0]  d;
  logic [7:0]  hi;
  int          failures = 0;
  int          samples_checked = 0;

  sac_ctrl u_sac_ctrl (
    .clk_i               (clk_i),
    .resetn_i            (resetn_i),
    .addr_i              (addr_i),
    .wdata_i             (wdata_i),
    .wr_i                (wr_i),
    .rd_i                (rd_i),
    .rdata_o             (rdata_o),
    .capture_input_pin_i (pin_i),
    .comparator2_i       (comparator2_live_output),
    .ramp_charge_o       (charge),
    .ramp_discharge_o    (discharge)
  );
  sac_ramp_model u_sac_ramp_model (
    .clk_i       (clk_i),
    .charge_i    (charge),
    .discharge_i (discharge),
    .force_en_i  (force_en),
    .force_val_i (force_val),
    .thresh_i    (thresh),
    .cmp_o       (comparator2_live_output)
  );

  initial
  forever #2.5 clk_i = ~clk_i;
  // reference counter: reloads on reset, one tick per clock
  always @(posedge clk_i)
    cnt_m <= resetn_i ? cnt_m + 16'h0001 : CNT_RESET_VAL;

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // window check, modulo 16 bits so a wrap inside the window is fine
  task automatic chk_rng(input logic [15:0] got, input logic [15:0] lo, input int span);
    samples_checked++;
    if (((got - lo) <= 16'(span)) !== 1'b1)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, lo);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] w);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= w;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // c is the counter value the read samples
  task automatic rd(input logic [3:0] a, output logic [7:0] q);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    #1 c = cnt_m;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 q = rdata_o;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // s=1 drives comparator 2, s=0 the pin; t marks the change
  task automatic src(input logic s, input logic lv);
    @(posedge clk_i);
    if (s)
      force_val <= lv;
    else
      pin_i <= lv;
    #1 t = cnt_m;
    cyc(3);
  endtask
  task automatic results;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // whole run is a few hundred cycles; allow ample margin
  initial
  begin
    #(5 * 20000);
    failures++;
    results;
  end

  initial
  begin
    void'($urandom(34849));
    thresh = 8'h10 + 8'($urandom % 32);
    // compare has no reset; loading it under reset keeps the match flag defined
    v = 16'($urandom);
    @(posedge clk_i);
    addr_i  <= ADDR_CMP_HIGH;
    wdata_i <= v[15:8];
    wr_i    <= 1'b1;
    @(posedge clk_i);
    addr_i  <= ADDR_CMP_LOW;
    wdata_i <= v[7:0];
    @(posedge clk_i);
    wr_i     <= 1'b0;
    resetn_i <= 1'b1;
    #1 chk_val(discharge, 1'b1);
    chk_val(rdata_o, 8'h00);
    rd(ADDR_TIMER_CTRL, d);
    chk_val(d, TCR_RESET_VAL);
    rd(ADDR_ANALOG_CTRL, d);
    chk_val(d, ACR_RESET_VAL);
    cyc(6);
    rd(ADDR_CNT_LOW, d);
    chk_val(d, c[7:0]);
    rd(ADDR_TIMER_STAT, d);
    chk_val(d[5], 1'b1);
    rd(ADDR_CNT_HIGH, d);
    chk_val(d, c[15:8]);
    // wrap flag left pending: entering mode 2 must charge at once
    wr(ADDR_TIMER_CTRL, 8'h02);
    force_en <= 1'b0;
    wr(ADDR_ANALOG_CTRL, 8'h06);
    cyc(2);
    #1 chk_val(charge, 1'b1);
    for (int n = 0; n < 300 && comparator2_live_output !== 1'b1; n++)
      @(posedge clk_i);
    #1 t = cnt_m;
    cyc(4);
    #1 chk_val({charge, discharge}, 2'b01);
    rd(ADDR_TIMER_STAT, d);
    chk_val({d[7], d[5]}, 2'b11);
    rd(ADDR_CAP_HIGH, hi);
    rd(ADDR_CAP_LOW, d);
    chk_rng({hi, d}, t - 16'h0003, 6);
    cyc(1);
    // next channel is chosen in the capture service, ahead of the next ramp
    thresh <= 8'h10 + 8'($urandom % 32);
    #1 chk_val(charge, 1'b1);
    wr(ADDR_ANALOG_CTRL, 8'h00);
    force_en <= 1'b1;
    // every source and edge: wrong edge and other source ignored
    for (int k = 0; k < 4; k++)
    begin
      wr(ADDR_ANALOG_CTRL, {5'h00, k[1], 2'h0});
      wr(ADDR_TIMER_CTRL, {6'h00, k[0], 1'b0});
      src(k[1], k[0]);
      rd(ADDR_TIMER_STAT, d);
      rd(ADDR_CAP_LOW, d);
      src(k[1], !k[0]);
      src(!k[1], 1'b0);
      src(!k[1], 1'b1);
      rd(ADDR_TIMER_STAT, d);
      chk_val(d[7], 1'b0);
      src(k[1], k[0]);
      v = t;
      rd(ADDR_TIMER_STAT, d);
      chk_val(d[7], 1'b1);
      rd(ADDR_CAP_HIGH, hi);
      src(k[1], !k[0]);
      src(k[1], k[0]);
      rd(ADDR_CAP_LOW, d);
      chk_rng({hi, d}, v, 4);
      rd(ADDR_TIMER_STAT, d);
      chk_val(d[7], 1'b0);
    end
    rd(ADDR_CNT_LOW, d);
    rd(ADDR_TIMER_STAT, d);
    chk_val(d[5], 1'b0);
    // mode 3 entry: stale match cleared before the mode bits
    v = cnt_m + 16'd200 + 16'($urandom % 64);
    wr(ADDR_CMP_HIGH, v[15:8]);
    wr(ADDR_CMP_LOW, v[7:0]);
    rd(ADDR_TIMER_STAT, d);
    rd(ADDR_CMP_LOW, d);
    wr(ADDR_ANALOG_CTRL, 8'h03);
    for (int n = 0; n < 400 && charge !== 1'b1; n++)
      @(posedge clk_i);
    #1 chk_rng(cnt_m, v, 5);
    rd(ADDR_TIMER_STAT, d);
    chk_val(d[6], 1'b1);
    rd(ADDR_CMP_LOW, d);
    rd(ADDR_TIMER_STAT, d);
    chk_val(d[6], 1'b0);
    wr(ADDR_ANALOG_CTRL, 8'h00);
    #1 chk_val(charge, 1'b0);
    wr(ADDR_ANALOG_CTRL, 8'h08);
    cyc(1);
    #1 chk_val(charge, 1'b1);
    rd(ADDR_ANALOG_CTRL, d);
    chk_val(d, 8'h08);
    wr(ADDR_ANALOG_CTRL, 8'h00);
    src(1'b1, 1'b1);
    rd(ADDR_ANALOG_STAT, d);
    chk_val(d[7:6], 2'b11);
    src(1'b1, 1'b0);
    wr(ADDR_ANALOG_STAT, 8'h02);
    rd(ADDR_ANALOG_STAT, d);
    chk_val(d[7:6], 2'b00);
    // compare registers must survive a mid-run reset
    v = 16'($urandom);
    wr(ADDR_CMP_HIGH, v[15:8]);
    wr(ADDR_CMP_LOW, v[7:0]);
    resetn_i <= 1'b0;
    cyc(3);
    resetn_i <= 1'b1;
    rd(ADDR_CMP_HIGH, hi);
    rd(ADDR_CMP_LOW, d);
    chk_val({hi, d}, v);
    wr(4'hf, 8'h5a);
    rd(4'hf, d);
    chk_val(d, 8'h00);
    results;
  end
endmodule
